// >>> rtl/vc_cap_pkg.sv
// Package for the virtual channel capability header registers
// Assumes APB with 32-bit data, one aligned word per register
package vc_cap_pkg;
    localparam logic [11:0] ADDR_HEADER          = 12'h200;
    localparam logic [11:0] ADDR_PORT_CAP_ONE    = 12'h204;
    localparam logic [11:0] ADDR_PORT_CAP_TWO    = 12'h208;
    localparam logic [11:0] ADDR_PORT_ROLE       = 12'h210;
    localparam logic [15:0] CAP_ID_VALUE         = 16'h0002;
    localparam logic [3:0]  CAP_VERSION_VALUE    = 4'h1;
    localparam logic [11:0] NEXT_PTR_RESET       = 12'h000;
    localparam int          CAP_ID_LSB           = 0;
    localparam int          CAP_VERSION_LSB      = 16;
    localparam int          NEXT_PTR_LSB         = 20;
    localparam int          EXTRA_COUNT_LSB      = 0;
    localparam int          LOW_PRIO_COUNT_LSB   = 4;
    localparam int          TIME_BASE_LSB        = 8;
    localparam int          ENTRY_SIZE_LSB       = 10;
    localparam int          ARB_CAP_LSB          = 0;
    localparam int          ARB_TABLE_OFF_LSB    = 24;
    localparam logic [2:0]  EXTRA_COUNT_VALUE    = 3'h0;
    localparam logic [2:0]  LOW_PRIO_COUNT_VALUE = 3'h0;
    localparam logic [1:0]  TIME_BASE_VALUE      = 2'h0;
    localparam logic [7:0]  ARB_CAP_VALUE        = 8'h00;
    localparam logic [7:0]  ARB_TABLE_OFF_VALUE  = 8'h00;
    // Arbitration table entry size encoding
    localparam logic [1:0]  ENTRY_ONE_BIT        = 2'h0;
    localparam logic [1:0]  ENTRY_TWO_BIT        = 2'h1;
    localparam logic [1:0]  ENTRY_FOUR_BIT       = 2'h2;
    localparam logic [1:0]  ENTRY_EIGHT_BIT      = 2'h3;
    // Channel arbitration capability bit positions
    localparam int          ARB_FIXED_RR_BIT     = 0;
    localparam int          ARB_WRR32_BIT        = 1;
    localparam int          ARB_WRR64_BIT        = 2;
    localparam int          ARB_WRR128_BIT       = 3;
    localparam logic [7:0]  ARB_CAP_DEFINED_MASK = 8'h0f;

    typedef struct packed {
        logic        sel;
        logic        enable;
        logic        write;
        logic [11:0] addr;
        logic [31:0] wdata;
    } apb_req_type;
endpackage

// >>> rtl/vc_cap_field_pack.sv
// Assembles the read-only capability words from their fields
// Assumes purely combinational use by the register bank
`timescale 1ns/1ps
module vc_cap_field_pack (
    input  wire logic        upstream_port,
    input  wire logic [11:0] next_capability_pointer,
    output logic      [31:0] header_word,
    output logic      [31:0] cap_one_word,
    output logic      [31:0] cap_two_word
);
    logic [1:0] port_arb_entry_size;

    assign port_arb_entry_size = upstream_port ? vc_cap_pkg::ENTRY_FOUR_BIT
                                               : vc_cap_pkg::ENTRY_ONE_BIT; // RQ7 RQ8

    always_comb begin
        header_word = 32'h0000_0000;
        header_word[vc_cap_pkg::CAP_ID_LSB +: 16]     = vc_cap_pkg::CAP_ID_VALUE; // RQ1
        header_word[vc_cap_pkg::CAP_VERSION_LSB +: 4] = vc_cap_pkg::CAP_VERSION_VALUE; // RQ2
        header_word[vc_cap_pkg::NEXT_PTR_LSB +: 12]   = next_capability_pointer; // RQ3
        cap_one_word = 32'h0000_0000; // RQ12
        cap_one_word[vc_cap_pkg::EXTRA_COUNT_LSB +: 3]    = vc_cap_pkg::EXTRA_COUNT_VALUE; // RQ4
        cap_one_word[vc_cap_pkg::LOW_PRIO_COUNT_LSB +: 3] = vc_cap_pkg::LOW_PRIO_COUNT_VALUE; // RQ5
        cap_one_word[vc_cap_pkg::TIME_BASE_LSB +: 2]      = vc_cap_pkg::TIME_BASE_VALUE; // RQ6
        cap_one_word[vc_cap_pkg::ENTRY_SIZE_LSB +: 2]     = port_arb_entry_size; // RQ7
        cap_two_word = 32'h0000_0000; // RQ12
        cap_two_word[vc_cap_pkg::ARB_CAP_LSB +: 8] =
            vc_cap_pkg::ARB_CAP_VALUE & vc_cap_pkg::ARB_CAP_DEFINED_MASK; // RQ9 RQ10
        cap_two_word[vc_cap_pkg::ARB_TABLE_OFF_LSB +: 8] = vc_cap_pkg::ARB_TABLE_OFF_VALUE; // RQ11
    end
endmodule

// >>> rtl/vc_capability_header_regs.sv
// APB register bank for the start of a switch port's VC capability structure
// Assumes an APB master on pclk; the lock input comes from the device core
//
// Contract
// RQ1: Header bits 15:0 read capability ID 0x2
// RQ2: Header bits 19:16 read version 0x1
// RQ3: Next pointer writable only under lock, resets 0
// RQ4: Extra channel count reads zero
// RQ5: Low-priority channel count reads zero
// RQ6: Arbitration time base reads zero
// RQ7: Entry size 0x2 upstream, 0x0 downstream
// RQ8: Entry size encodes 1, 2, 4, 8 bits
// RQ9: Channel arbitration capability reads zero
// RQ10: Capability bits flag schemes; 4-7 reserved
// RQ11: Arbitration table offset reads zero
// RQ12: Read-only writes ignored; reserved bits read zero
`timescale 1ns/1ps
module vc_capability_header_regs (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    input  wire logic [3:0]  pstrb,
    output logic             pready,
    output logic      [31:0] prdata,
    output logic             pslverr,
    input  wire logic        config_write_lock
);
    vc_cap_pkg::apb_req_type req;
    logic [11:0] next_capability_pointer_r;
    logic        upstream_port_r;
    logic [31:0] prdata_nxt;
    logic        pslverr_nxt;
    logic [31:0] header_word;
    logic [31:0] cap_one_word;
    logic [31:0] cap_two_word;
    logic        access;
    logic        wr_access;
    logic        rd_access;
    logic        addr_mapped;

    // One assignment for the whole carrier keeps a single driver on it
    assign req = {psel, penable, pwrite, paddr, pwdata};

    assign rd_access   = req.sel && req.enable && !req.write;
    assign addr_mapped = (req.addr == vc_cap_pkg::ADDR_HEADER)
                      || (req.addr == vc_cap_pkg::ADDR_PORT_CAP_ONE)
                      || (req.addr == vc_cap_pkg::ADDR_PORT_CAP_TWO)
                      || (req.addr == vc_cap_pkg::ADDR_PORT_ROLE);

    assign access    = req.sel && !req.enable;
    assign wr_access = req.sel && req.enable && req.write;
    // Zero-wait-state slave
    assign pready    = 1'b1;

    vc_cap_field_pack u_pack (
        .upstream_port           (upstream_port_r),
        .next_capability_pointer (next_capability_pointer_r),
        .header_word             (header_word),
        .cap_one_word            (cap_one_word),
        .cap_two_word            (cap_two_word)
    );

    // Next pointer: lock-gated, byte lanes honoured
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            next_capability_pointer_r <= vc_cap_pkg::NEXT_PTR_RESET; // RQ3
        end else if (wr_access && config_write_lock
                     && req.addr == vc_cap_pkg::ADDR_HEADER) begin
            if (pstrb[2]) begin
                next_capability_pointer_r[3:0] <= req.wdata[23:20]; // RQ3
            end
            if (pstrb[3]) begin
                next_capability_pointer_r[11:4] <= req.wdata[31:24]; // RQ3
            end
        end
    end

    // Port role: set when this instance serves the upstream port
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            upstream_port_r <= 1'b0;
        end else if (wr_access && req.addr == vc_cap_pkg::ADDR_PORT_ROLE && pstrb[0]) begin
            upstream_port_r <= req.wdata[0];
        end
    end

    // Read data and error decode, registered at setup
    always_comb begin
        prdata_nxt  = 32'h0000_0000;
        pslverr_nxt = 1'b0;
        case (req.addr)
            vc_cap_pkg::ADDR_HEADER:       prdata_nxt = header_word;
            vc_cap_pkg::ADDR_PORT_CAP_ONE: prdata_nxt = cap_one_word;
            vc_cap_pkg::ADDR_PORT_CAP_TWO: prdata_nxt = cap_two_word;
            vc_cap_pkg::ADDR_PORT_ROLE:    prdata_nxt = {31'h0, upstream_port_r};
            default:                       pslverr_nxt = 1'b1;
        endcase
        if (req.write) begin
            prdata_nxt = 32'h0000_0000; // RQ12
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0000_0000;
        end else if (access) begin
            prdata <= prdata_nxt;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pslverr <= 1'b0;
        end else if (access) begin
            pslverr <= pslverr_nxt;
        end else if (!req.sel) begin
            pslverr <= 1'b0;
        end
    end

    hdr_id_a: assert property (@(posedge pclk) disable iff (!presetn)
        rd_access && paddr == vc_cap_pkg::ADDR_HEADER |-> prdata[15:0] == 16'h0002) // RQ1
        else $error("capability id wrong");
    hdr_ptr_read_a: assert property (@(posedge pclk) disable iff (!presetn)
        rd_access && paddr == vc_cap_pkg::ADDR_HEADER
        |-> prdata[31:20] == next_capability_pointer_r) // RQ3
        else $error("pointer read back wrong");
    ptr_other_addr_a: assert property (@(posedge pclk) disable iff (!presetn)
        wr_access && paddr != vc_cap_pkg::ADDR_HEADER
        |=> $stable(next_capability_pointer_r)) // RQ3
        else $error("pointer changed by other address");
    arb_cap_reserved_a: assert property (@(posedge pclk) disable iff (!presetn)
        rd_access && paddr == vc_cap_pkg::ADDR_PORT_CAP_TWO
        |-> prdata[7:4] == 4'h0) // RQ10
        else $error("reserved arbitration bits set");
    unmapped_err_a: assert property (@(posedge pclk) disable iff (!presetn)
        psel && penable && !addr_mapped |-> pslverr && prdata == 32'h0000_0000) // RQ12
        else $error("unmapped access not flagged");
    mapped_ok_a: assert property (@(posedge pclk) disable iff (!presetn)
        psel && penable && addr_mapped |-> !pslverr) // RQ12
        else $error("mapped access flagged");
    write_rdata_a: assert property (@(posedge pclk) disable iff (!presetn)
        psel && penable && pwrite |-> prdata == 32'h0000_0000) // RQ12
        else $error("write returned data");
    idle_err_a: assert property (@(posedge pclk) disable iff (!presetn)
        !psel |=> !pslverr)
        else $error("error flag left standing");
    role_write_a: assert property (@(posedge pclk) disable iff (!presetn)
        wr_access && paddr == vc_cap_pkg::ADDR_PORT_ROLE && pstrb[0]
        |=> upstream_port_r == $past(pwdata[0])) // RQ7
        else $error("port role write lost");
    hdr_version_a: assert property (@(posedge pclk) disable iff (!presetn)
        psel && penable && !pwrite && paddr == 12'h200 |-> prdata[19:16] == 4'h1) // RQ2
        else $error("version field wrong");
    ptr_locked_a: assert property (@(posedge pclk) disable iff (!presetn)
        psel && penable && pwrite && !config_write_lock
        |=> $stable(next_capability_pointer_r)) // RQ3
        else $error("pointer changed without lock");
    ptr_write_a: assert property (@(posedge pclk) disable iff (!presetn)
        psel && penable && pwrite && config_write_lock && paddr == 12'h200 && pstrb == 4'hf
        |=> next_capability_pointer_r == $past(pwdata[31:20])) // RQ3
        else $error("pointer write lost");
    counts_zero_a: assert property (@(posedge pclk) disable iff (!presetn)
        rd_access && paddr == vc_cap_pkg::ADDR_PORT_CAP_ONE
        |-> prdata[9:0] == 10'h000) // RQ4 RQ5 RQ6
        else $error("count or time base nonzero");
    entry_size_a: assert property (@(posedge pclk) disable iff (!presetn)
        psel && penable && !pwrite && paddr == 12'h204
        |-> prdata[11:10] == (upstream_port_r ? 2'h2 : 2'h0)) // RQ7 RQ8
        else $error("entry size wrong for port role");
    cap_two_a: assert property (@(posedge pclk) disable iff (!presetn)
        psel && penable && !pwrite && paddr == 12'h208 |-> prdata == 32'h0) // RQ9 RQ10 RQ11
        else $error("second capability word nonzero");
    reserved_zero_a: assert property (@(posedge pclk) disable iff (!presetn)
        psel && penable && !pwrite && paddr == 12'h204 |-> prdata[31:12] == 20'h0
        && prdata[7] == 1'b0 && prdata[3] == 1'b0) // RQ12
        else $error("reserved bits nonzero");

    read_hdr_c: cover property (@(posedge pclk) psel && penable && !pwrite && paddr == 12'h200);
    locked_wr_c: cover property (@(posedge pclk) psel && penable && pwrite && config_write_lock);
    upstream_c: cover property (@(posedge pclk) upstream_port_r && psel && paddr == 12'h204);
    bad_addr_c: cover property (@(posedge pclk) psel && penable && pslverr);
endmodule

// >>> testbench/vc_capability_header_regs_tb.sv
// Self-checking bench for the VC capability header register bank
// Assumes a zero-wait APB slave on pclk with an active-low async reset
`timescale 1ns/1ps
module vc_capability_header_regs_tb;
    logic        pclk              = 1'b0;
    logic        presetn           = 1'b0;
    logic        psel              = 1'b0;
    logic        penable           = 1'b0;
    logic        pwrite            = 1'b0;
    logic [11:0] paddr             = 12'h000;
    logic [31:0] pwdata            = 32'h0000_0000;
    logic [3:0]  pstrb             = 4'hf;
    logic        config_write_lock = 1'b0;
    logic        pready;
    logic [31:0] prdata;
    logic        pslverr;
    int          err_total         = 0;
    int          compares          = 0;
    logic [32:0] expq[$];
    logic [32:0] exp_v;
    logic [31:0] rnd;

    always #50 pclk = ~pclk;

    vc_capability_header_regs i_dut (
        .pclk              (pclk),
        .presetn           (presetn),
        .psel              (psel),
        .penable           (penable),
        .pwrite            (pwrite),
        .paddr             (paddr),
        .pwdata            (pwdata),
        .pstrb             (pstrb),
        .pready            (pready),
        .prdata            (prdata),
        .pslverr           (pslverr),
        .config_write_lock (config_write_lock)
    );

    task automatic complete_run;
        $display("Counts: compares=%0d mismatches=%0d", compares, err_total);
        if (err_total == 0 && compares > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    // One APB transfer; reads leave their expected {pslverr, prdata} in the queue
    task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
                        input logic [32:0] e);
        if (!w) begin
            expq.push_back(e);
        end
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) begin
            @(posedge pclk);
        end
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask

    // Read results are taken at the edge that completes the access phase
    always @(posedge pclk) begin
        if (psel === 1'b1 && penable === 1'b1 && pready === 1'b1 && pwrite === 1'b0) begin
            exp_v = expq.pop_front();
            compares++;
            if ({pslverr, prdata} !== exp_v) begin
                err_total++;
                $display("[FAIL] %0t read %h got %h expected %h", $time, paddr,
                         {pslverr, prdata}, exp_v);
            end
        end
    end

    initial begin
        #(5000 * 100);
        err_total++;
        $display("[FAIL] %0t watchdog expired", $time);
        complete_run();
    end

    initial begin
        rnd = $urandom(32'h617b);
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        xfer(1'b0, 12'h200, $urandom, 33'h0_0001_0002);
        xfer(1'b0, 12'h204, $urandom, 33'h0_0000_0000);
        xfer(1'b0, 12'h208, $urandom, 33'h0_0000_0000);
        xfer(1'b0, 12'h210, $urandom, 33'h0_0000_0000);
        $display("Test reset values done");
        xfer(1'b1, 12'h200, $urandom | 32'hfff0_0000, 33'h0);
        xfer(1'b0, 12'h200, $urandom, 33'h0_0001_0002);
        xfer(1'b1, 12'h204, 32'hffff_ffff, 33'h0);
        xfer(1'b1, 12'h208, 32'hffff_ffff, 33'h0);
        xfer(1'b0, 12'h204, $urandom, 33'h0_0000_0000);
        xfer(1'b0, 12'h208, $urandom, 33'h0_0000_0000);
        $display("Test writes without lock done");
        config_write_lock <= 1'b1;
        rnd = $urandom;
        xfer(1'b1, 12'h200, rnd, 33'h0);
        xfer(1'b0, 12'h200, $urandom, {1'b0, rnd[31:20], 20'h1_0002});
        config_write_lock <= 1'b0;
        xfer(1'b1, 12'h200, ~rnd, 33'h0);
        xfer(1'b0, 12'h200, $urandom, {1'b0, rnd[31:20], 20'h1_0002});
        $display("Test locked pointer write done");
        xfer(1'b1, 12'h210, 32'h0000_0001, 33'h0);
        xfer(1'b0, 12'h204, $urandom, 33'h0_0000_0800);
        xfer(1'b0, 12'h210, $urandom, 33'h0_0000_0001);
        xfer(1'b1, 12'h210, 32'h0000_0000, 33'h0);
        xfer(1'b0, 12'h204, $urandom, 33'h0_0000_0000);
        $display("Test port role done");
        xfer(1'b0, 12'h300, $urandom, 33'h1_0000_0000);
        $display("Test unmapped address done");
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        xfer(1'b0, 12'h200, $urandom, 33'h0_0001_0002);
        xfer(1'b0, 12'h208, $urandom, 33'h0_0000_0000);
        $display("Test mid-run reset done");
        repeat (2) @(posedge pclk);
        complete_run();
    end
endmodule
